// file: verilog/ata_cmd_pkg.sv
// constants for the task-file command interpreter
// Function
// - opcode 27h with device/head 111D xxxx is decoded as the native max query.
// - the query returns the true maximum address whatever limit was set before.
// - the 48-bit answer is spread over sector number and both cylinder registers, low/high by HOB.
// - on the query only ABT may be set in error; BSY, DF, COR read 0.
// - opcodes 20h and 21h both start a sector read; the retry bit is ignored.
// - a sector is read from the media in full before it is offered to the host.
// - sector data leaves through the data register one 16-bit word per read.
// - an uncorrectable media error stops the command at the failing sector.
// - the sector count gives the sectors to read, zero meaning 256.
// - sector number is the start sector when L=0 and LBA bits 7:0 when L=1.
// - cylinder low/high are the start cylinder when L=0 and LBA bits 23:8 when L=1.
// - device/head carries L in bit 6, device in bit 4 and head or LBA 27:24 in bits 3:0.
// - at the end sector count holds the sectors not moved, zero unless an error hit.
// - at the end the address registers hold the last transferred sector, or the failing sector after an error.
// - a read may report UNC, IDN, ABT; CRC, TON, AMN stay 0; BSY, DF, COR read 0.
package ata_cmd_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_ERR = 8'h04;
    localparam logic [7:0] OFF_CNT = 8'h08;
    localparam logic [7:0] OFF_SEC = 8'h0C;
    localparam logic [7:0] OFF_CYL_LO = 8'h10;
    localparam logic [7:0] OFF_CYL_HI = 8'h14;
    localparam logic [7:0] OFF_DEV = 8'h18;
    localparam logic [7:0] OFF_CMD = 8'h1C;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_IRQ_ST = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

    // status bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_COR = 2;
    localparam int ST_ERR = 0;

    // error bit positions
    localparam int ER_CRC = 7;
    localparam int ER_UNC = 6;
    localparam int ER_IDN = 4;
    localparam int ER_ABT = 2;
    localparam int ER_TON = 1;
    localparam int ER_AMN = 0;

    // field positions
    localparam int DEV_L = 6;
    localparam int CTRL_HOB = 7;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_DRQ = 2;

    // reset values and opcodes
    localparam logic [7:0] STAT_RST = 8'h50;
    localparam logic [7:0] DEV_RST = 8'hA0;
    localparam logic [7:0] CMD_MAX_EXT = 8'h27;
    localparam logic [7:0] CMD_READ = 8'h20;
    localparam logic [7:0] CMD_RETRY_MASK = 8'hFE;
endpackage : ata_cmd_pkg

// file: verilog/ata_read_native_max.sv
// task-file command interpreter: native max query and PIO sector read
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module ata_read_native_max #(
    parameter int unsigned WORDS = 256,
    parameter int unsigned HEADS = 16,
    parameter int unsigned SPT = 63
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [47:0] native_max_lba,
    output logic media_req,
    output logic [27:0] media_lba,
    input wire logic media_valid,
    input wire logic [15:0] media_data,
    input wire logic media_uncorr,
    output logic irq
);
    localparam int IW = $clog2(WORDS) + 1;
    localparam logic [IW-1:0] LAST_W = IW'(WORDS - 1);

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_MAXQ,
        PH_FETCH,
        PH_XFER,
        PH_DONE
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] err;
        logic [7:0] stat;
        logic [7:0] cnt;
        logic [7:0] sec;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev;
        logic [7:0] hob_sec;
        logic [7:0] hob_lo;
        logic [7:0] hob_hi;
        logic [7:0] ctrl;
        logic [7:0] irq_st;
        logic [7:0] irq_mask;
        logic [8:0] left;
        logic [IW-1:0] widx;
        logic req;
        logic fail;
        logic [31:0] rdata;
        logic [WORDS-1:0][15:0] sbuf;
    } state_t;

    state_t s_ff;
    state_t nxt_s;

    // decode used only by the error answer; the read mux decodes paddr itself
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= ata_cmd_pkg::OFF_IRQ_MASK) && (a[1:0] == 2'h0);
    endfunction : mapped

    // task-file address to media block
    function automatic logic [27:0] media_addr(
        input logic [7:0] sec,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] dev
    );
        logic [31:0] chs;
        chs = (32'({hi, lo}) * 32'(HEADS) + 32'(dev[3:0])) * 32'(SPT);
        chs = chs + 32'(sec) - 32'h1;
        if (dev[ata_cmd_pkg::DEV_L]) begin
            media_addr = {dev[3:0], hi, lo, sec};
        end else begin
            media_addr = chs[27:0];
        end
    endfunction : media_addr

    // step the task-file address by one sector, as {dev, hi, lo, sec}
    function automatic logic [31:0] next_addr(
        input logic [7:0] sec,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [7:0] dev
    );
        logic [27:0] lba;
        logic [15:0] cyl;
        lba = {dev[3:0], hi, lo, sec} + 28'h1;
        cyl = {hi, lo};
        next_addr = {dev, hi, lo, sec};
        if (dev[ata_cmd_pkg::DEV_L]) begin
            next_addr = {dev[7:4], lba};
        end else if (32'(sec) < SPT) begin
            next_addr[7:0] = sec + 8'h01;
        end else begin
            next_addr[7:0] = 8'h01;
            if (32'(dev[3:0]) < HEADS - 1) begin
                next_addr[27:24] = dev[3:0] + 4'h1;
            end else begin
                next_addr[27:24] = 4'h0;
                cyl = cyl + 16'h0001;
                next_addr[23:8] = {cyl[15:8], cyl[7:0]};
            end
        end
    endfunction : next_addr

    logic acc_wr;
    logic acc_rd;
    logic busy;
    logic [27:0] start_lba;
    logic [31:0] step;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;

    assign acc_wr = psel && penable && pwrite;
    assign acc_rd = psel && penable && !pwrite;
    assign busy = s_ff.stat[ata_cmd_pkg::ST_BSY];
    assign start_lba = media_addr(s_ff.sec, s_ff.cyl_lo, s_ff.cyl_hi, s_ff.dev);
    assign step = next_addr(s_ff.sec, s_ff.cyl_lo, s_ff.cyl_hi, s_ff.dev);

    // zero-wait slave; unmapped words answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = s_ff.rdata;
    assign media_req = s_ff.req;
    assign media_lba = start_lba;
    assign irq = |(s_ff.irq_st & s_ff.irq_mask);

    // whole next state in one place
    always_comb begin
        nxt_s = s_ff;
        irq_set = 8'h00;
        irq_clr = 8'h00;

        // read data latched in setup so the answer comes from a flop
        if (psel && !penable) begin
            unique case (paddr)
                ata_cmd_pkg::OFF_DATA: nxt_s.rdata = {16'h0000, s_ff.sbuf[s_ff.widx[IW-2:0]]};
                ata_cmd_pkg::OFF_ERR: nxt_s.rdata = {24'h0, s_ff.err};
                ata_cmd_pkg::OFF_CNT: nxt_s.rdata = {24'h0, s_ff.cnt};
                ata_cmd_pkg::OFF_SEC: nxt_s.rdata = {24'h0,
                    s_ff.ctrl[ata_cmd_pkg::CTRL_HOB] ? s_ff.hob_sec : s_ff.sec};
                ata_cmd_pkg::OFF_CYL_LO: nxt_s.rdata = {24'h0,
                    s_ff.ctrl[ata_cmd_pkg::CTRL_HOB] ? s_ff.hob_lo : s_ff.cyl_lo};
                ata_cmd_pkg::OFF_CYL_HI: nxt_s.rdata = {24'h0,
                    s_ff.ctrl[ata_cmd_pkg::CTRL_HOB] ? s_ff.hob_hi : s_ff.cyl_hi};
                ata_cmd_pkg::OFF_DEV: nxt_s.rdata = {24'h0, s_ff.dev};
                ata_cmd_pkg::OFF_CMD: nxt_s.rdata = {24'h0, s_ff.stat};
                ata_cmd_pkg::OFF_CTRL: nxt_s.rdata = {24'h0, s_ff.ctrl};
                ata_cmd_pkg::OFF_IRQ_ST: nxt_s.rdata = {24'h0, s_ff.irq_st};
                ata_cmd_pkg::OFF_IRQ_MASK: nxt_s.rdata = {24'h0, s_ff.irq_mask};
                default: nxt_s.rdata = 32'h0000_0000;
            endcase
        end

        // software writes; task file is frozen while busy
        if (acc_wr) begin
            unique case (paddr)
                ata_cmd_pkg::OFF_CTRL: nxt_s.ctrl = pwdata[7:0];
                ata_cmd_pkg::OFF_IRQ_ST: irq_clr = pwdata[7:0];
                ata_cmd_pkg::OFF_IRQ_MASK: nxt_s.irq_mask = pwdata[7:0];
                default: ;
            endcase
        end
        if (acc_wr && !busy) begin
            unique case (paddr)
                ata_cmd_pkg::OFF_CNT: nxt_s.cnt = pwdata[7:0];
                ata_cmd_pkg::OFF_SEC: nxt_s.sec = pwdata[7:0];
                ata_cmd_pkg::OFF_CYL_LO: nxt_s.cyl_lo = pwdata[7:0];
                ata_cmd_pkg::OFF_CYL_HI: nxt_s.cyl_hi = pwdata[7:0];
                ata_cmd_pkg::OFF_DEV: nxt_s.dev = pwdata[7:0];
                default: ;
            endcase
        end

        // command start: busy at once, old error cleared
        if (acc_wr && !busy && paddr == ata_cmd_pkg::OFF_CMD) begin
            nxt_s.stat[ata_cmd_pkg::ST_BSY] = 1'b1;
            nxt_s.stat[ata_cmd_pkg::ST_ERR] = 1'b0;
            nxt_s.stat[ata_cmd_pkg::ST_DRQ] = 1'b0;
            nxt_s.err = 8'h00;
            nxt_s.fail = 1'b0;
            nxt_s.widx = '0;
            nxt_s.left = (s_ff.cnt == 8'h00) ? 9'h100 : {1'b0, s_ff.cnt};
            if (pwdata[7:0] == ata_cmd_pkg::CMD_MAX_EXT) begin
                nxt_s.phase = PH_MAXQ;
            end else if ((pwdata[7:0] & ata_cmd_pkg::CMD_RETRY_MASK) == ata_cmd_pkg::CMD_READ) begin
                // start beyond the drive, or CHS sector 0, has no id
                if ({20'h0, start_lba} > native_max_lba ||
                    (!s_ff.dev[ata_cmd_pkg::DEV_L] && s_ff.sec == 8'h00)) begin
                    nxt_s.err[ata_cmd_pkg::ER_IDN] = 1'b1;
                    nxt_s.fail = 1'b1;
                    nxt_s.phase = PH_DONE;
                end else begin
                    nxt_s.req = 1'b1;
                    nxt_s.phase = PH_FETCH;
                end
            end else begin
                nxt_s.err[ata_cmd_pkg::ER_ABT] = 1'b1;
                nxt_s.fail = 1'b1;
                nxt_s.left = 9'h000;
                nxt_s.phase = PH_DONE;
            end
        end

        unique case (s_ff.phase)
            PH_IDLE: ;
            // native max ignores any host limit: it comes straight from the port
            PH_MAXQ: begin
                nxt_s.sec = native_max_lba[7:0];
                nxt_s.cyl_lo = native_max_lba[15:8];
                nxt_s.cyl_hi = native_max_lba[23:16];
                nxt_s.hob_sec = native_max_lba[31:24];
                nxt_s.hob_lo = native_max_lba[39:32];
                nxt_s.hob_hi = native_max_lba[47:40];
                nxt_s.err = 8'h00;
                nxt_s.stat = ata_cmd_pkg::STAT_RST;
                nxt_s.phase = PH_IDLE;
                irq_set[ata_cmd_pkg::IRQ_DONE] = 1'b1;
            end
            // whole sector lands in the buffer before the host sees DRQ
            PH_FETCH: begin
                if (media_uncorr) begin
                    nxt_s.req = 1'b0;
                    nxt_s.err[ata_cmd_pkg::ER_UNC] = 1'b1;
                    nxt_s.fail = 1'b1;
                    nxt_s.phase = PH_DONE;
                end else if (media_valid) begin
                    nxt_s.sbuf[s_ff.widx[IW-2:0]] = media_data;
                    nxt_s.widx = s_ff.widx + 1'b1;
                    if (s_ff.widx == LAST_W) begin
                        nxt_s.req = 1'b0;
                        nxt_s.widx = '0;
                        nxt_s.stat[ata_cmd_pkg::ST_DRQ] = 1'b1;
                        irq_set[ata_cmd_pkg::IRQ_DRQ] = 1'b1;
                        nxt_s.phase = PH_XFER;
                    end
                end
            end
            // each data read moves one word; last word of a sector moves on
            PH_XFER: begin
                if (acc_rd && paddr == ata_cmd_pkg::OFF_DATA) begin
                    nxt_s.widx = s_ff.widx + 1'b1;
                    if (s_ff.widx == LAST_W) begin
                        nxt_s.widx = '0;
                        nxt_s.left = s_ff.left - 9'h001;
                        nxt_s.stat[ata_cmd_pkg::ST_DRQ] = 1'b0;
                        if (s_ff.left == 9'h001) begin
                            nxt_s.phase = PH_DONE;
                        end else begin
                            // address steps only when another sector follows
                            {nxt_s.dev, nxt_s.cyl_hi, nxt_s.cyl_lo, nxt_s.sec} = step;
                            nxt_s.req = 1'b1;
                            nxt_s.phase = PH_FETCH;
                        end
                    end
                end
            end
            // final values and busy release land together
            PH_DONE: begin
                nxt_s.cnt = s_ff.left[7:0];
                nxt_s.stat = ata_cmd_pkg::STAT_RST;
                nxt_s.stat[ata_cmd_pkg::ST_ERR] = s_ff.fail;
                nxt_s.phase = PH_IDLE;
                irq_set[ata_cmd_pkg::IRQ_DONE] = 1'b1;
                irq_set[ata_cmd_pkg::IRQ_ERR] = s_ff.fail;
            end
        endcase

        // sticky events: a new event beats a same-cycle clear
        nxt_s.irq_st = (s_ff.irq_st & ~irq_clr) | irq_set;
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.phase <= PH_IDLE;
            s_ff.stat <= ata_cmd_pkg::STAT_RST;
            s_ff.dev <= ata_cmd_pkg::DEV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cmd_s;
        acc_wr && !busy && paddr == ata_cmd_pkg::OFF_CMD;
    endsequence

    sequence max_cmd_s;
        cmd_s ##0 pwdata[7:0] == ata_cmd_pkg::CMD_MAX_EXT;
    endsequence

    sequence pop_s;
        s_ff.phase == PH_XFER && acc_rd && paddr == ata_cmd_pkg::OFF_DATA;
    endsequence

    native_max_a: assert property (max_cmd_s |-> ##2 !busy &&
        s_ff.hob_hi == $past(native_max_lba[47:40], 1) && s_ff.sec == $past(native_max_lba[7:0], 1))
        else $error("native max not placed");

    max_errbits_a: assert property (s_ff.phase == PH_MAXQ |=>
        (s_ff.err & 8'hFB) == 8'h00 && !s_ff.stat[ata_cmd_pkg::ST_COR])
        else $error("query reported wrong bits");

    retry_ignored_a: assert property (cmd_s ##0 pwdata[7:1] == 7'h10 |=>
        s_ff.phase == PH_FETCH || s_ff.err[ata_cmd_pkg::ER_IDN])
        else $error("read opcode not started");

    no_early_drq_a: assert property (s_ff.phase == PH_FETCH |->
        !s_ff.stat[ata_cmd_pkg::ST_DRQ])
        else $error("data offered before sector read");

    word_step_a: assert property (pop_s ##0 s_ff.widx != LAST_W |=>
        s_ff.widx == $past(s_ff.widx) + 1'b1)
        else $error("data read did not advance");

    uncorr_stop_a: assert property (s_ff.phase == PH_FETCH && media_uncorr |=>
        s_ff.phase == PH_DONE ##1 (!busy && s_ff.err[ata_cmd_pkg::ER_UNC] && s_ff.stat[ata_cmd_pkg::ST_ERR]))
        else $error("media error not ending command");

    // only reads take the count; an aborted opcode leaves nothing to move
    zero_count_a: assert property (cmd_s ##0 s_ff.cnt == 8'h00 && pwdata[7:1] == 7'h10 |=>
        s_ff.left == 9'h100)
        else $error("zero count is not 256");

    remaining_zero_a: assert property (s_ff.phase == PH_DONE && !s_ff.fail |=> s_ff.cnt == 8'h00)
        else $error("remaining count not zero");

    err_clean_a: assert property (!busy |-> (s_ff.err & 8'h83) == 8'h00 &&
        !s_ff.stat[ata_cmd_pkg::ST_DF])
        else $error("forbidden error bit set");

    busy_hold_a: assert property (s_ff.phase != PH_IDLE |-> busy)
        else $error("busy dropped mid command");

    sequence done_s;
        s_ff.phase == PH_DONE;
    endsequence

    sequence unknown_cmd_s;
        cmd_s ##0 pwdata[7:0] != ata_cmd_pkg::CMD_MAX_EXT && pwdata[7:1] != 7'h10;
    endsequence

    // the query ties with an abort as the shortest command: one cycle busy, then the answer
    max_busy_a: assert property (max_cmd_s |=> busy ##1 !busy)
        else $error("query busy window wrong");

    abort_end_a: assert property (unknown_cmd_s |=> done_s ##1 (!busy &&
        s_ff.err[ata_cmd_pkg::ER_ABT] && s_ff.stat[ata_cmd_pkg::ST_ERR] && s_ff.cnt == 8'h00))
        else $error("unknown opcode not aborted");

    sector_ready_a: assert property (s_ff.phase == PH_FETCH && !media_uncorr && media_valid &&
        s_ff.widx == LAST_W |=> s_ff.phase == PH_XFER && s_ff.stat[ata_cmd_pkg::ST_DRQ] && !media_req)
        else $error("full sector not offered");

    last_pop_a: assert property (pop_s ##0 s_ff.widx == LAST_W |=> !s_ff.stat[ata_cmd_pkg::ST_DRQ])
        else $error("data request not dropped");

    // host must find the failing sector, so the address may not step on a fault
    uncorr_addr_a: assert property (s_ff.phase == PH_FETCH && media_uncorr |=>
        $stable({s_ff.dev, s_ff.cyl_hi, s_ff.cyl_lo, s_ff.sec}))
        else $error("failing sector address lost");

    done_irq_a: assert property (done_s |=> s_ff.irq_st[ata_cmd_pkg::IRQ_DONE])
        else $error("done event lost");

endmodule : ata_read_native_max

`default_nettype wire

// file: bench/media_model.sv
// media side model: answers sector fetches with 16-bit words
`timescale 1ns/1ns
`default_nettype none
module media_model #(
    parameter int unsigned WORDS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic media_req,
    input wire logic [27:0] media_lba,
    input wire logic slow,
    input wire logic bad_en,
    input wire logic [27:0] bad_lba,
    output logic media_valid,
    output logic [15:0] media_data,
    output logic media_uncorr
);
    int words;
    logic gap;
    logic hold;
    // whole sector handed over before the host may see it; slow mode stalls every other cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            words <= 0;
            gap <= 1'b0;
            hold <= 1'b0;
            media_valid <= 1'b0;
            media_uncorr <= 1'b0;
            media_data <= 16'h0000;
        end else begin
            media_valid <= 1'b0;
            media_uncorr <= 1'b0;
            media_data <= ~media_data; // idle data toggles, never stale
            gap <= slow & ~gap;
            if (!media_req) begin
                words <= 0;
                hold <= 1'b0;
            end else if (!hold && !gap && words < WORDS) begin
                if (bad_en && media_lba == bad_lba) begin
                    media_uncorr <= 1'b1;
                    hold <= 1'b1;
                end else begin
                    media_valid <= 1'b1;
                    media_data <= {media_lba[7:0], 8'(words)};
                    words <= words + 1;
                end
            end
        end
    end
endmodule : media_model
`default_nettype wire

// file: bench/tb_top.sv
// bench: task-file commands over the register bus, checked against expectations
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int WD = 4;
    localparam int HD = 16;
    localparam int SP = 63;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_err;
    logic media_req, media_valid, media_uncorr, slow, bad_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [31:0] seed = 32'h1DDF;
    logic [47:0] native_max_lba, nm;
    logic [27:0] media_lba, bad_lba;
    logic [15:0] media_data;
    int miscompares, num_checks, cyc;
    logic [31:0] expq[$];

    ata_read_native_max #(.WORDS(WD), .HEADS(HD), .SPT(SP)) i_ata_read_native_max (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .native_max_lba(native_max_lba), .media_req(media_req), .media_lba(media_lba),
        .media_valid(media_valid), .media_data(media_data), .media_uncorr(media_uncorr), .irq(irq));
    media_model #(.WORDS(WD)) i_media_model (
        .pclk(pclk), .presetn(presetn), .media_req(media_req), .media_lba(media_lba), .slow(slow),
        .bad_en(bad_en), .bad_lba(bad_lba), .media_valid(media_valid), .media_data(media_data),
        .media_uncorr(media_uncorr));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // {device/head, cyl high, cyl low, sector} for a block in either addressing mode
    function automatic logic [31:0] taddr(input logic lm, input int l);
        int c;
        c = l / (SP * HD);
        if (lm) begin
            return {4'hE, 4'(l >> 24), 8'(l >> 16), 8'(l >> 8), 8'(l)};
        end
        return {4'hA, 4'((l / SP) % HD), 8'(c >> 8), 8'(c), 8'(l % SP + 1)};
    endfunction : taddr

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one transfer: setup, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; the loop ends on pready, and only the hang guard bounds it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        apb(1'b0, a, 32'h0, x);
    endtask : rd

    task automatic chkr(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        rd(a, x);
        chk(what, e, x & m);
    endtask : chkr

    // poll status until the masked bits match; bounded so a hang is reported
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        int n;
        logic [31:0] x;
        n = 0;
        do begin
            rd(ata_cmd_pkg::OFF_CMD, x);
            n++;
        end while ((x[7:0] & m) !== v && n < 3000);
        if ((x[7:0] & m) !== v) begin
            miscompares++;
            $display("Error status poll expected %h seen %h", v, x[7:0] & m);
        end
    endtask : poll

    task automatic rd_cmd(input logic [7:0] op, input logic lm, input int lba0, input int cnt, input int bad);
        int n;
        int nx;
        logic [31:0] t;
        logic [31:0] x;
        n = (cnt == 0) ? 256 : cnt;
        nx = (bad < 0) ? n : bad;
        t = xs();
        slow <= t[0];
        bad_en <= (bad >= 0);
        bad_lba <= 28'(lba0 + bad);
        t = taddr(lm, lba0);
        wr(ata_cmd_pkg::OFF_CNT, 32'(8'(cnt)));
        wr(ata_cmd_pkg::OFF_SEC, {24'h0, t[7:0]});
        wr(ata_cmd_pkg::OFF_CYL_LO, {24'h0, t[15:8]});
        wr(ata_cmd_pkg::OFF_CYL_HI, {24'h0, t[23:16]});
        wr(ata_cmd_pkg::OFF_DEV, {24'h0, t[31:24]});
        wr(ata_cmd_pkg::OFF_CMD, {24'h0, op});
        for (int k = 0; k < nx; k++) begin
            poll(8'h08, 8'h08);
            for (int w = 0; w < WD; w++) begin
                expq.push_back({16'h0, 8'(lba0 + k), 8'(w)});
            end
            for (int w = 0; w < WD; w++) begin
                rd(ata_cmd_pkg::OFF_DATA, x);
                chk("data word", expq.pop_front(), x);
            end
        end
        poll(8'h80, 8'h00);
        t = taddr(lm, lba0 + ((bad < 0) ? n - 1 : bad));
        chkr("left count", ata_cmd_pkg::OFF_CNT, 32'hFF, 32'(8'(n - nx)));
        chkr("end sector", ata_cmd_pkg::OFF_SEC, 32'hFF, {24'h0, t[7:0]});
        chkr("end cyl low", ata_cmd_pkg::OFF_CYL_LO, 32'hFF, {24'h0, t[15:8]});
        chkr("end cyl high", ata_cmd_pkg::OFF_CYL_HI, 32'hFF, {24'h0, t[23:16]});
        chkr("end head", ata_cmd_pkg::OFF_DEV, 32'h0F, {28'h0, t[27:24]});
        chkr("read error", ata_cmd_pkg::OFF_ERR, 32'hFF, (bad < 0) ? 32'h0 : 32'h40);
        chkr("read status", ata_cmd_pkg::OFF_CMD, 32'hFD, (bad < 0) ? 32'h50 : 32'h51);
    endtask : rd_cmd

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard: generous for a 256-sector read at slow media
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow = 1'b0;
        bad_en = 1'b0;
        bad_lba = 28'h0;
        native_max_lba = 48'hFFFFFFFFFFFF;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chkr("reset status", ata_cmd_pkg::OFF_CMD, 32'hFF, 32'h50);
        chkr("reset device", ata_cmd_pkg::OFF_DEV, 32'hFF, 32'hA0);
        // native max query, both byte halves, twice with fresh values
        for (int p = 0; p < 2; p++) begin
            nm = 48'({xs(), xs()});
            nm[47] = 1'b1;
            native_max_lba <= nm;
            wr(ata_cmd_pkg::OFF_DEV, 32'hE0);
            wr(ata_cmd_pkg::OFF_CMD, 32'h27);
            poll(8'h80, 8'h00);
            for (int h = 0; h < 2; h++) begin
                wr(ata_cmd_pkg::OFF_CTRL, 32'(h) << 7);
                for (int i = 0; i < 3; i++) begin
                    chkr("max byte", ata_cmd_pkg::OFF_SEC + 8'(4 * i), 32'hFF, 32'(nm[8 * (3 * h + i) +: 8]));
                end
            end
            wr(ata_cmd_pkg::OFF_CTRL, 32'h0);
            chkr("max error", ata_cmd_pkg::OFF_ERR, 32'hFF, 32'h0);
            chkr("max status", ata_cmd_pkg::OFF_CMD, 32'hE5, 32'h40);
        end
        // reads: retry bit set, CHS across a track end, media fault, count of zero
        wr(ata_cmd_pkg::OFF_IRQ_MASK, 32'h1);
        rd_cmd(8'h21, 1'b1, 28'h0123456, 3, -1);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(ata_cmd_pkg::OFF_IRQ_ST, 32'h7);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ata_cmd_pkg::OFF_IRQ_MASK, 32'h0);
        rd_cmd(8'h20, 1'b0, 2267, 2, -1);
        chkr("irq pending", ata_cmd_pkg::OFF_IRQ_ST, 32'h1, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_cmd(8'h20, 1'b1, 28'h00ABC00, 4, 1);
        r = xs();
        rd_cmd(8'h21, 1'b1, int'(r[26:0]), 0, -1);
        wr(ata_cmd_pkg::OFF_CMD, 32'h99);
        poll(8'h80, 8'h00);
        chkr("abort error", ata_cmd_pkg::OFF_ERR, 32'hFF, 32'h4);
        // CHS sector 0 has no id: refused before any media access
        wr(ata_cmd_pkg::OFF_SEC, 32'h0);
        wr(ata_cmd_pkg::OFF_DEV, 32'hA0);
        wr(ata_cmd_pkg::OFF_CMD, 32'h20);
        poll(8'h80, 8'h00);
        chkr("id error", ata_cmd_pkg::OFF_ERR, 32'hFF, 32'h10);
        rd(8'hFC, q);
        chk("unmapped", 32'h1, {31'h0, slv_err});
        chk("unmapped data", 32'h0, q);
        results();
    end
endmodule : tb_top
`default_nettype wire
